// ===== inc/ashp_pkg.sv
package ashp_pkg;

    localparam int WORD_W     = 24;
    localparam int FIFO_DEPTH = 16;
    localparam int FIFO_AW    = 4;

    // Serial word lengths as bit counts.
    localparam logic [4:0] LEN_SHORT = 5'h10;
    localparam logic [4:0] LEN_LONG  = 5'h18;

    // Self-clock half period; a least time, so it rounds up.
    localparam int         CLK_MHZ       = 40;
    localparam int         SCLK_HALF_NS  = 100;
    localparam int         SCLK_HALF_CYC = (SCLK_HALF_NS * CLK_MHZ + 999) / 1000;
    localparam logic [2:0] HALF_RELOAD   = 3'(SCLK_HALF_CYC - 1);

    localparam logic [23:0] CTRL_RST = 24'h000000;
    localparam logic [23:0] CAL_RST  = 24'h000000;

    typedef enum logic [1:0] {
        ASHP_IDLE  = 2'b00,
        ASHP_READ  = 2'b01,
        ASHP_WRITE = 2'b10
    } ashp_state_e;

    // Pin group that passes the synchroniser together.
    typedef struct packed {
        logic mode;
        logic sclk;
        logic rfs_n;
        logic tfs_n;
        logic sel;
        logic din;
    } ashp_pins_s;

    localparam ashp_pins_s PINS_IDLE = 6'h0c;

endpackage

// ===== hw/ashp_top.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Conversion word buffer
// ----------------------------------------------------------------
module ashp_fifo #(
    parameter int W  = 24,
    parameter int D  = 16,
    parameter int AW = 4
) (
    input  wire logic          clk,
    input  wire logic          rst_b,
    input  wire logic [W-1:0]  in_data,
    input  wire logic          in_valid,
    output logic               in_ready,
    output logic [W-1:0]       out_data,
    output logic               out_valid,
    input  wire logic          out_ready,
    output logic [AW:0]        level
);
    logic [W-1:0]  mem [D];
    logic [AW-1:0] wp_r;
    logic [AW-1:0] rp_r;
    logic [AW:0]   cnt_nxt;
    logic          push;
    logic          pop;

    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;
    assign out_valid = (level != '0);
    assign out_data  = mem[rp_r];

    // Ready is registered from the next count so it is exact, not early.
    always_comb begin
        cnt_nxt = level + (AW+1)'(push) - (AW+1)'(pop);
    end

    // Pointers, count and ready.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            wp_r     <= '0;
            rp_r     <= '0;
            level    <= '0;
            in_ready <= 1'b1;
        end else begin
            if (push) begin
                wp_r <= wp_r + 1'b1;
            end
            if (pop) begin
                rp_r <= rp_r + 1'b1;
            end
            level    <= cnt_nxt;
            in_ready <= (cnt_nxt != (AW+1)'(D));
        end
    end

    // Storage needs no reset; empty entries are never read.
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wp_r] <= in_data;
        end
    end
endmodule // ashp_fifo

// ----------------------------------------------------------------
// Serial host port
// ----------------------------------------------------------------
module ashp_top (
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        mode_self_pin,
    input  wire logic        register_select,
    input  wire logic        read_frame_sync_n,
    input  wire logic        write_frame_sync_n,
    input  wire logic        sclk_in,
    output logic             sclk_out,
    output logic             sclk_oe,
    input  wire logic        serial_data_line_in,
    output logic             serial_data_line_out,
    output logic             serial_data_line_oe,
    output logic             conversion_ready_n,
    input  wire logic [23:0] conv_word,
    input  wire logic        conv_valid,
    output logic             conv_ready,
    input  wire logic        word_len_24,
    input  wire logic        cal_read_sel,
    output logic [23:0]      control_word,
    output logic [23:0]      cal_word,
    output logic             write_done
);
    ashp_pkg::ashp_pins_s  pin_now;
    ashp_pkg::ashp_pins_s  pin_m_r;
    ashp_pkg::ashp_pins_s  pin_s_r;
    ashp_pkg::ashp_pins_s  pin_d_r;
    ashp_pkg::ashp_state_e state_r;
    logic                  mode_r;
    logic [2:0]            half_r;
    logic                  sclk_q_r;
    logic                  frame_n;
    logic                  run;
    logic                  tick;
    logic                  rise;
    logic                  fall;
    logic                  src_out_r;
    logic [4:0]            len_r;
    logic [4:0]            cnt_r;
    logic [23:0]           shift_r;
    logic [23:0]           win_r;
    logic                  wsel_r;
    logic [23:0]           out_reg_r;
    logic [4:0]            flush_r;
    logic                  start_rd;
    logic                  start_wr;
    logic                  rd_done;
    logic                  wr_fin;
    logic [23:0]           rd_word;
    logic [23:0]           fifo_data;
    logic                  fifo_valid;
    logic                  drain;
    logic [4:0]            fifo_level;

    assign pin_now = {mode_self_pin, sclk_in, read_frame_sync_n,
                      write_frame_sync_n, register_select, serial_data_line_in};

    // Two-stage synchroniser plus one stage for edge detection.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            pin_m_r <= ashp_pkg::PINS_IDLE;
            pin_s_r <= ashp_pkg::PINS_IDLE;
            pin_d_r <= ashp_pkg::PINS_IDLE;
        end else begin
            pin_m_r <= pin_now;
            pin_s_r <= pin_m_r;
            pin_d_r <= pin_s_r;
        end
    end

    // The strap is taken only between transfers so a word never changes clocking.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            mode_r <= 1'b0;
        end else if (state_r == ashp_pkg::ASHP_IDLE) begin
            mode_r <= pin_s_r.mode;
        end
    end

    // Frame sync of the transfer in progress; a high level pauses it.
    assign frame_n = (state_r == ashp_pkg::ASHP_WRITE) ? pin_s_r.tfs_n : pin_s_r.rfs_n;

    // Own clock runs only in self mode, inside a frame.
    assign run  = mode_r & (state_r != ashp_pkg::ASHP_IDLE) & !frame_n;
    assign tick = run & (half_r == 3'h0);

    // Edges come from the own divider or from the host clock.
    assign rise = mode_r ? (tick & !sclk_q_r)
                         : (pin_s_r.sclk & !pin_d_r.sclk & !frame_n);
    assign fall = mode_r ? (tick & sclk_q_r)
                         : (!pin_s_r.sclk & pin_d_r.sclk & !frame_n);

    // Divider; the clock starts low so the host first sees a rising edge on the MSB.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            half_r   <= ashp_pkg::HALF_RELOAD;
            sclk_q_r <= 1'b0;
        end else if (state_r == ashp_pkg::ASHP_IDLE) begin
            half_r   <= ashp_pkg::HALF_RELOAD;
            sclk_q_r <= 1'b0;
        end else if (run) begin
            if (tick) begin
                half_r   <= ashp_pkg::HALF_RELOAD;
                sclk_q_r <= ~sclk_q_r;
            end else begin
                half_r <= half_r - 3'h1;
            end
        end
    end

    // Output reads are refused while ready is high.
    assign start_rd = (state_r == ashp_pkg::ASHP_IDLE) & pin_d_r.rfs_n & !pin_s_r.rfs_n
                    & (!pin_s_r.sel | cal_read_sel | !conversion_ready_n);
    assign start_wr = (state_r == ashp_pkg::ASHP_IDLE) & pin_d_r.tfs_n & !pin_s_r.tfs_n
                    & !start_rd;
    assign rd_done  = (state_r == ashp_pkg::ASHP_READ) & fall & (cnt_r == len_r - 5'h01);
    assign wr_fin   = (state_r == ashp_pkg::ASHP_WRITE) & fall
                    & (cnt_r == ashp_pkg::LEN_LONG);

    // Source word; high select with the calibration strap picks calibration.
    assign rd_word = !pin_s_r.sel ? control_word
                   : (cal_read_sel ? cal_word : out_reg_r);

    // Transfer sequencer; the bit counter survives frame pauses.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state_r   <= ashp_pkg::ASHP_IDLE;
            src_out_r <= 1'b0;
            len_r     <= ashp_pkg::LEN_LONG;
            cnt_r     <= 5'h00;
            shift_r   <= 24'h000000;
            win_r     <= 24'h000000;
            wsel_r    <= 1'b0;
        end else begin
            unique case (state_r)
                ashp_pkg::ASHP_IDLE: begin
                    cnt_r <= 5'h00;
                    if (start_rd) begin
                        state_r   <= ashp_pkg::ASHP_READ;
                        src_out_r <= pin_s_r.sel & !cal_read_sel;
                        shift_r   <= rd_word;
                        len_r     <= (pin_s_r.sel & !cal_read_sel & !word_len_24)
                                   ? ashp_pkg::LEN_SHORT : ashp_pkg::LEN_LONG;
                    end else if (start_wr) begin
                        state_r   <= ashp_pkg::ASHP_WRITE;
                        src_out_r <= 1'b0;
                        wsel_r    <= pin_s_r.sel;
                    end
                end
                ashp_pkg::ASHP_READ: begin
                    if (rd_done) begin
                        state_r <= ashp_pkg::ASHP_IDLE;
                    end else if (fall) begin
                        shift_r <= {shift_r[22:0], 1'b0};
                        cnt_r   <= cnt_r + 5'h01;
                    end
                end
                ashp_pkg::ASHP_WRITE: begin
                    if (wr_fin) begin
                        state_r <= ashp_pkg::ASHP_IDLE;
                    end else if (rise && cnt_r != ashp_pkg::LEN_LONG) begin
                        win_r <= {win_r[22:0], pin_s_r.din};
                        cnt_r <= cnt_r + 5'h01;
                    end
                end
                default: begin
                    state_r <= ashp_pkg::ASHP_IDLE;
                end
            endcase
        end
    end

    // Draining stalls during an output read; the buffer then holds the late words.
    assign drain = (state_r != ashp_pkg::ASHP_READ) | !src_out_r;

    ashp_fifo #(
        .W  (ashp_pkg::WORD_W),
        .D  (ashp_pkg::FIFO_DEPTH),
        .AW (ashp_pkg::FIFO_AW)
    ) u_fifo (
        .clk       (clk),
        .rst_b     (rst_b),
        .in_data   (conv_word),
        .in_valid  (conv_valid),
        .in_ready  (conv_ready),
        .out_data  (fifo_data),
        .out_valid (fifo_valid),
        .out_ready (drain),
        .level     (fifo_level)
    );

    // Output register and ready; words that came in during an output read are flushed unseen.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            out_reg_r          <= 24'h000000;
            flush_r            <= 5'h00;
            conversion_ready_n <= 1'b1;
        end else if (rd_done && src_out_r) begin
            flush_r            <= fifo_level;
            conversion_ready_n <= 1'b1;
        end else if (fifo_valid && drain) begin
            if (flush_r != 5'h00) begin
                flush_r <= flush_r - 5'h01;
            end else begin
                out_reg_r          <= fifo_data;
                conversion_ready_n <= 1'b0;
            end
        end
    end

    // Register writes land where the select pointed at the start.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            control_word <= ashp_pkg::CTRL_RST;
            cal_word     <= ashp_pkg::CAL_RST;
            write_done   <= 1'b0;
        end else begin
            write_done <= wr_fin;
            if (wr_fin && !wsel_r) begin
                control_word <= win_r;
            end
            if (wr_fin && wsel_r) begin
                cal_word <= win_r;
            end
        end
    end

    // Pin drivers; data floats whenever the read frame is paused or over.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            sclk_out             <= 1'b0;
            sclk_oe              <= 1'b0;
            serial_data_line_out <= 1'b0;
            serial_data_line_oe  <= 1'b0;
        end else begin
            sclk_out             <= sclk_q_r;
            sclk_oe              <= mode_r & (state_r != ashp_pkg::ASHP_IDLE);
            serial_data_line_out <= shift_r[23];
            serial_data_line_oe  <= (state_r == ashp_pkg::ASHP_READ)
                                  & !pin_s_r.rfs_n;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    refused_read_a: assert property (@(posedge clk) disable iff (!rst_b)
        (state_r == ashp_pkg::ASHP_IDLE && pin_d_r.rfs_n && !pin_s_r.rfs_n
         && pin_s_r.sel && !cal_read_sel && conversion_ready_n && !start_wr)
        |=> state_r == ashp_pkg::ASHP_IDLE)
        else $error("output read started while ready high");

    ready_release_a: assert property (@(posedge clk) disable iff (!rst_b)
        (rd_done && src_out_r) |=> conversion_ready_n ##1 !serial_data_line_oe)
        else $error("ready or data not released after last bit");

    ready_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
        (state_r == ashp_pkg::ASHP_READ && src_out_r) |-> !conversion_ready_n)
        else $error("ready rose during output read");

    reg_ready_a: assert property (@(posedge clk) disable iff (!rst_b)
        (state_r != ashp_pkg::ASHP_IDLE && !src_out_r && !conversion_ready_n)
        |=> !conversion_ready_n)
        else $error("register access changed ready");

    ext_clock_a: assert property (@(posedge clk) disable iff (!rst_b)
        (!mode_r && state_r == ashp_pkg::ASHP_IDLE) |=> !sclk_oe)
        else $error("clock driven in external mode");

    self_clock_a: assert property (@(posedge clk) disable iff (!rst_b)
        (mode_r && state_r != ashp_pkg::ASHP_IDLE && !frame_n) |=> sclk_oe)
        else $error("self clock not driven in transfer");

    write_commit_a: assert property (@(posedge clk) disable iff (!rst_b)
        (wr_fin && !wsel_r) |=> (control_word == $past(win_r)) && write_done)
        else $error("control write not committed");

    pause_float_a: assert property (@(posedge clk) disable iff (!rst_b)
        (state_r == ashp_pkg::ASHP_READ && !rd_done)
        |=> serial_data_line_oe == !$past(pin_s_r.rfs_n))
        else $error("data enable not following frame sync");

    short_word_a: assert property (@(posedge clk) disable iff (!rst_b)
        (start_rd && pin_s_r.sel && !cal_read_sel && !word_len_24)
        |=> len_r == ashp_pkg::LEN_SHORT)
        else $error("short word length not applied");
endmodule // ashp_top

// ===== test/ashp_host_model.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Host serial port model
// ----------------------------------------------------------------
module ashp_host_model (
    input  wire logic clk,
    input  wire logic sclk_out,
    input  wire logic sclk_oe,
    input  wire logic dout,
    input  wire logic doe,
    input  wire logic rdy_n,
    output logic      sclk_h,
    output logic      rd_frame_n,
    output logic      wr_frame_n,
    output logic      sel,
    output logic      din
);
    logic pause_oe;
    logic pause_rdy;
    int   stalls;

    // Frames idle high and the host clock idles low between transfers.
    initial begin
        sclk_h     = 1'b0;
        rd_frame_n = 1'b1;
        wr_frame_n = 1'b1;
        sel        = 1'b0;
        din        = 1'b0;
        pause_oe   = 1'b0;
        pause_rdy  = 1'b0;
        stalls     = 0;
    end

    // A floating data line reads unknown, so a missing drive passes only a check that expects unknown bits.
    function automatic logic line_bit();
        return doe ? dout : 1'bx;
    endfunction

    // Bounded wait for the device clock to reach a level.
    task automatic wait_sclk(input logic lvl);
        int t;
        t = 0;
        while ((sclk_oe & sclk_out) !== lvl && t < 64) begin
            @(negedge clk);
            t++;
        end
        if (t >= 64) stalls++;
    endtask

    // One framed transfer; a pause lifts the frame while the clock is low.
    task automatic xfer(input logic self, input logic rd, input logic s, input int n,
                        input logic [23:0] wd, input int pause, output logic [23:0] got);
        got = 24'h000000;
        @(negedge clk);
        sel        = s;
        din        = wd[23];
        rd_frame_n = ~rd;
        wr_frame_n = rd;
        for (int i = 0; i < n; i++) begin
            if (i == pause) begin
                repeat (4) @(negedge clk); // Let the device see the last fall first.
                rd_frame_n = 1'b1;
                wr_frame_n = 1'b1;
                repeat (12) @(negedge clk);
                pause_oe   = doe;
                pause_rdy  = rdy_n;
                rd_frame_n = ~rd;
                wr_frame_n = rd;
                repeat (4) @(negedge clk);
            end
            if (self) begin
                wait_sclk(1'b1);
                got = {got[22:0], line_bit()};
                wait_sclk(1'b0);
            end else begin
                repeat (4) @(negedge clk);
                sclk_h = 1'b1;
                repeat (4) @(negedge clk);
                got    = {got[22:0], line_bit()};
                sclk_h = 1'b0;
            end
            if (i < 23) din = wd[22-i];
        end
        repeat (6) @(negedge clk);
        rd_frame_n = 1'b1;
        wr_frame_n = 1'b1;
        din        = ~din;
    endtask
endmodule // ashp_host_model

// ===== test/adc_serial_host_port_tb.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Serial host port bench
// ----------------------------------------------------------------
module adc_serial_host_port_tb;
    logic        clk;
    logic        rst_b;
    logic        mode_self;
    logic        sclk_h;
    logic        sclk_out;
    logic        sclk_oe;
    logic        sclk_pin;
    logic        rd_frame_n;
    logic        wr_frame_n;
    logic        sel;
    logic        din;
    logic        dout;
    logic        doe;
    logic        rdy_n;
    logic        rdy_q;
    logic [23:0] conv_word;
    logic        conv_valid;
    logic        conv_ready;
    logic        len_24;
    logic        cal_sel;
    logic [23:0] control_word;
    logic [23:0] cal_word;
    logic        write_done;
    int          err_total;
    int          comparisons;
    int          done_cnt;
    int          rdy_moves;

    // Whoever owns the clock pin drives it; the host side idles low.
    assign sclk_pin = sclk_oe ? sclk_out : sclk_h;

    always #12.5 clk = ~clk;

    // Counts write pulses and every move of the ready line.
    always @(posedge clk) begin
        rdy_q <= rdy_n;
        if (write_done === 1'b1) done_cnt++;
        if (rst_b === 1'b1 && rdy_q !== rdy_n) rdy_moves++;
    end

    ashp_top i_dut (
        .clk                  (clk),
        .rst_b                (rst_b),
        .mode_self_pin        (mode_self),
        .register_select      (sel),
        .read_frame_sync_n    (rd_frame_n),
        .write_frame_sync_n   (wr_frame_n),
        .sclk_in              (sclk_pin),
        .sclk_out             (sclk_out),
        .sclk_oe              (sclk_oe),
        .serial_data_line_in  (din),
        .serial_data_line_out (dout),
        .serial_data_line_oe  (doe),
        .conversion_ready_n   (rdy_n),
        .conv_word            (conv_word),
        .conv_valid           (conv_valid),
        .conv_ready           (conv_ready),
        .word_len_24          (len_24),
        .cal_read_sel         (cal_sel),
        .control_word         (control_word),
        .cal_word             (cal_word),
        .write_done           (write_done)
    );

    ashp_host_model i_host (
        .clk        (clk),
        .sclk_out   (sclk_out),
        .sclk_oe    (sclk_oe),
        .dout       (dout),
        .doe        (doe),
        .rdy_n      (rdy_n),
        .sclk_h     (sclk_h),
        .rd_frame_n (rd_frame_n),
        .wr_frame_n (wr_frame_n),
        .sel        (sel),
        .din        (din)
    );

    task automatic report_and_stop();
        $display("Counts: %0d mismatches in %0d comparisons", err_total, comparisons);
        if (err_total == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask

    // Valid stays up across a burst, so no edge sees it dropped and raised.
    task automatic push_n(input logic [23:0] base, input int n);
        int t;
        for (int i = 0; i < n; i++) begin
            conv_word  = base + 24'(i);
            conv_valid = 1'b1;
            t = 0;
            while (conv_ready !== 1'b1 && t < 50) begin
                @(negedge clk);
                t++;
            end
            if (t >= 50) begin
                err_total++;
                report_and_stop();
            end
            @(negedge clk);
        end
        conv_valid = 1'b0;
    endtask

    task automatic sc_reset();
        check(24'({rdy_n, conv_ready, sclk_oe, doe, write_done}), 24'h000018);
        check(control_word | cal_word, 24'h000000);
    endtask

    task automatic sc_refused();
        logic [23:0] got;
        i_host.xfer(1'b0, 1'b1, 1'b1, 4, 24'h000000, 99, got);
        check(got, 24'h00000x);
        check(24'(rdy_n), 24'h000001);
    endtask

    task automatic sc_regs();
        logic [23:0] got;
        int          d0;
        int          m0;
        d0 = done_cnt;
        m0 = rdy_moves;
        i_host.xfer(1'b0, 1'b0, 1'b0, 24, 24'h5a3c96, 99, got);
        tick(4);
        check(control_word, 24'h5a3c96);
        i_host.xfer(1'b0, 1'b0, 1'b1, 24, 24'hc3e187, 9, got);
        tick(4);
        check(cal_word, 24'hc3e187);
        check(24'(done_cnt - d0), 24'h000002);
        i_host.xfer(1'b0, 1'b1, 1'b0, 24, 24'h000000, 99, got);
        check(got, 24'h5a3c96);
        cal_sel = 1'b1;
        i_host.xfer(1'b0, 1'b1, 1'b1, 24, 24'h000000, 99, got);
        cal_sel = 1'b0;
        check(got, 24'hc3e187);
        check(24'(rdy_moves - m0), 24'h000000);
    endtask

    task automatic sc_newest();
        logic [23:0] got;
        push_n(24'h111111, 1);
        tick(10);
        push_n(24'h222222, 1);
        tick(10);
        check(24'(rdy_n), 24'h000000);
        i_host.xfer(1'b0, 1'b1, 1'b1, 24, 24'h000000, 10, got);
        check(got, 24'h222222);
        check(24'({i_host.pause_oe, i_host.pause_rdy}), 24'h000000);
        check(24'({rdy_n, doe}), 24'h000002);
    endtask

    // Words arriving mid-read fill the buffer and are then thrown away.
    task automatic sc_discard();
        logic [23:0] got;
        push_n(24'h333333, 1);
        tick(10);
        fork
            i_host.xfer(1'b0, 1'b1, 1'b1, 24, 24'h000000, 99, got);
            begin
                tick(20);
                push_n(24'h400000, 16);
                tick(3);
                check(24'({conv_ready, rdy_n}), 24'h000000);
            end
        join
        tick(24);
        check(got, 24'h333333);
        check(24'({rdy_n, conv_ready}), 24'h000003);
    endtask

    task automatic sc_self();
        logic [23:0] got;
        push_n(24'h5a5a5a, 1);
        mode_self = 1'b1;
        len_24    = 1'b0;
        tick(10);
        i_host.xfer(1'b1, 1'b1, 1'b1, 16, 24'h000000, 99, got);
        check(got, 24'h005a5a);
        check(24'({rdy_n, sclk_oe, doe}), 24'h000004);
        len_24 = 1'b1;
        i_host.xfer(1'b1, 1'b0, 1'b0, 24, 24'h0f1e2d, 99, got);
        tick(4);
        check(control_word, 24'h0f1e2d);
        check(24'({sclk_oe, rdy_n}), 24'h000001);
        i_host.xfer(1'b1, 1'b1, 1'b0, 24, 24'h000000, 99, got);
        check(got, 24'h0f1e2d);
        mode_self = 1'b0;
    endtask

    // A host wait that ran out of time is a mismatch and ends the run.
    always @(posedge clk) begin
        if (i_host.stalls != 0) begin
            err_total++;
            report_and_stop();
        end
    end

    // A hung run is cut short and counted as a mismatch.
    initial begin
        repeat (60000) @(posedge clk);
        err_total++;
        report_and_stop();
    end

    initial begin
        clk         = 1'b0;
        rst_b       = 1'b0;
        mode_self   = 1'b0;
        conv_word   = 24'h000000;
        conv_valid  = 1'b0;
        len_24      = 1'b1;
        cal_sel     = 1'b0;
        err_total   = 0;
        comparisons = 0;
        done_cnt    = 0;
        rdy_moves   = 0;
        tick(10);
        rst_b = 1'b1;
        tick(8);
        sc_reset();
        sc_refused();
        sc_regs();
        sc_newest();
        sc_discard();
        sc_self();
        report_and_stop();
    end
endmodule // adc_serial_host_port_tb
